// File: hdl/pcx_crossbar.sv
// Priority pin crossbar with port data registers on APB
// Functional notes
// RULE1: First async serial port, when enabled, always takes pins zero and one.
// RULE2: Peripherals with enable bits clear never appear on any pin.
// RULE3: Enabled serial peripherals get all their signals together.
// RULE4: Pins go to peripherals in the fixed priority order of signals.
// RULE5: Unallocated pins act as GPIO with byte and single-bit access.
// RULE6: Allocated pins are driven by their peripheral; port writes ignored.
// RULE7: Ordinary port reads return the actual pin level.
// RULE8: Read-modify-write reads return the port latch contents.
// RULE9: A read right after a write may return the previous pin level.
// RULE10: All port drivers are off until the global enable is set.
// RULE11: Pins assigned to peripheral inputs never have their driver on.
// RULE12: Software configures the crossbar first and then leaves it alone.
// RULE13: Pins are allocated upward from port zero pin zero, next free pin.
// RULE14: Analog port-one pins are skipped and read as zero.
// RULE15: Memory-bus reserve withholds write, read and latch strobe pins; the code withholds the latch strobe pin only when D_EMIF_MUX is set.
// RULE16: Allocation is recomputed from enables and acts on the next cycle.
// RULE17: Each allocated pin's level goes to its peripheral and the read path.
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module pcx_crossbar
   import pcx_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral side
   input wire logic [NUM_SIG-1:0] periphOut,
   input wire logic [NUM_SIG-1:0] periphDrive,
   input wire logic spiThreeWire,
   output logic [NUM_SIG-1:0] periphIn,
   output logic [NUM_SIG-1:0] periphHasPin,
   // Port pins
   input wire logic [NUM_PIN-1:0] pinIn,
   output logic [NUM_PIN-1:0] pinOut,
   output logic [NUM_PIN-1:0] pinOutEnN
);
   pcx_state_t stateReg;
   pcx_state_t stateNext;

   logic [NUM_SIG-1:0] sigEnable;
   logic [NUM_PIN-1:0] pinSkip;
   logic [NUM_PIN-1:0] pinOwned;
   logic [NUM_PIN-1:0][SIGW-1:0] pinSig;
   logic [NUM_SIG-1:0] sigHasPin;
   logic [NUM_SIG-1:0][SIGW-1:0] sigPin;
   logic [NUM_PIN-1:0] pinReadLevel;
   logic [NUM_PIN-1:0] latchBits;
   logic [NUM_PIN-1:0] pushPull;
   logic [NUM_PIN-1:0] driveNext;
   logic [NUM_PIN-1:0] valueNext;
   logic [2:0] cexCount;
   logic globalEnable;

   // Decoded configuration fields
   assign globalEnable = stateReg.cfgC[C_GLOBAL];
   assign cexCount = stateReg.cfgA[A_CEX_MSB:A_CEX_LSB];
   assign latchBits = stateReg.latch;
   assign pushPull = stateReg.outMode;

   // Enable of every signal from the configuration bits, the select line also gated by spiThreeWire
   always_comb begin
      sigEnable = '0;
      sigEnable[SIG_SER0_TX] = stateReg.cfgA[A_UART0]; //RULE1
      sigEnable[SIG_SER0_RX] = stateReg.cfgA[A_UART0]; //RULE3
      sigEnable[SIG_SCK] = stateReg.cfgA[A_SPI]; //RULE3
      sigEnable[SIG_MISO] = stateReg.cfgA[A_SPI];
      sigEnable[SIG_MOSI] = stateReg.cfgA[A_SPI];
      sigEnable[SIG_NSS] = stateReg.cfgA[A_SPI] && !spiThreeWire;
      sigEnable[SIG_SDA] = stateReg.cfgA[A_SMB]; //RULE3
      sigEnable[SIG_SCL] = stateReg.cfgA[A_SMB];
      sigEnable[SIG_SER1_TX] = stateReg.cfgC[C_UART1]; //RULE3
      sigEnable[SIG_SER1_RX] = stateReg.cfgC[C_UART1];
      // Counter outputs in order, a count above six gives six
      for (int i = 0; i < NUM_CEX; i++) begin
         sigEnable[SIG_CNT_OUT + i] = (cexCount > 3'(i));
      end
      sigEnable[SIG_EXT_CLK] = stateReg.cfgA[A_EXT_CLK];
      sigEnable[SIG_CMP0] = stateReg.cfgA[A_CMP0];
      sigEnable[SIG_CMP1] = stateReg.cfgB[B_CMP1];
      sigEnable[SIG_T0] = stateReg.cfgB[B_T0];
      sigEnable[SIG_INT0] = stateReg.cfgB[B_INT0];
      sigEnable[SIG_T1] = stateReg.cfgB[B_T1];
      sigEnable[SIG_INT1] = stateReg.cfgB[B_INT1];
      sigEnable[SIG_T2] = stateReg.cfgB[B_T2];
      sigEnable[SIG_T2_EXT] = stateReg.cfgB[B_T2_EXT];
      sigEnable[SIG_T4] = stateReg.cfgD[D_T4];
      sigEnable[SIG_T4_EXT] = stateReg.cfgD[D_T4_EXT];
      sigEnable[SIG_CLK_OUT] = stateReg.cfgB[B_CLK_OUT];
      sigEnable[SIG_CNV0] = stateReg.cfgC[C_CNV0];
      sigEnable[SIG_CNV2] = stateReg.cfgD[D_CNV2];
   end

   // Pins removed from allocation
   always_comb begin
      pinSkip = '0;
      for (int i = 0; i < 8; i++) begin
         pinSkip[PORT_ONE_BASE + i] = !stateReg.inMode[i]; //RULE14
      end
      // Strobe pins kept for the memory bus
      if (stateReg.cfgC[C_EMIF]) begin
         pinSkip[EMIF_WR_PIN] = 1'b1; //RULE15
         pinSkip[EMIF_RD_PIN] = 1'b1; //RULE15
         pinSkip[EMIF_ALE_PIN] = stateReg.cfgD[D_EMIF_MUX]; //RULE15
      end
   end

   // Priority allocation of free pins
   pcx_allocator u_alloc (
      .sigEnable(sigEnable),
      .pinSkip(pinSkip),
      .pinOwned(pinOwned),
      .pinSig(pinSig),
      .sigHasPin(sigHasPin),
      .sigPin(sigPin)
   );

   // Filtered level with analog port-one pins reading zero
   always_comb begin
      pinReadLevel = stateReg.level;
      for (int i = 0; i < 8; i++) begin
         if (!stateReg.inMode[i]) begin
            pinReadLevel[PORT_ONE_BASE + i] = 1'b0; //RULE14
         end
      end
   end

   // Per-pin output selection
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PIN; gp++) begin : g_pin
         logic [SIGW-1:0] owner;
         logic odOnly;
         logic sigVal;
         assign owner = pinSig[gp];
         assign odOnly = OPEN_DRAIN_MASK[owner];
         assign sigVal = periphOut[owner];
         // Output value and driver enable of one pin
         always_comb begin
            valueNext[gp] = latchBits[gp];
            driveNext[gp] = 1'b0;
            if (!globalEnable) begin
               driveNext[gp] = 1'b0; //RULE10
            end else if (pinOwned[gp]) begin
               valueNext[gp] = sigVal; //RULE6
               if (INPUT_ONLY_MASK[owner]) begin
                  driveNext[gp] = 1'b0; //RULE11
               end else if (odOnly || !pushPull[gp]) begin
                  driveNext[gp] = periphDrive[owner] && !sigVal;
               end else begin
                  driveNext[gp] = periphDrive[owner];
               end
            end else begin
               driveNext[gp] = pushPull[gp] || !latchBits[gp]; //RULE5
            end
         end
      end
   endgenerate

   // Pin levels routed to owning peripherals
   genvar gs;
   generate
      for (gs = 0; gs < NUM_SIG; gs++) begin : g_sig
         assign periphIn[gs] = (globalEnable && sigHasPin[gs]) ?
            stateReg.level[sigPin[gs]] : 1'b1; //RULE17
         assign periphHasPin[gs] = globalEnable && sigHasPin[gs]; //RULE2
      end
   endgenerate

   // APB decode
   logic setupRead;
   logic accessWrite;
   logic [7:0] bank;
   logic [1:0] portSel;
   logic addrOk;

   // Register bank and port number from the address
   assign bank = paddr & ADDR_BANK_MASK;
   assign portSel = paddr[ADDR_PORT_SEL_LSB +: 2];
   assign setupRead = psel && !penable && !pwrite;
   assign accessWrite = psel && penable && pwrite;

   // Aligned addresses of known registers only
   always_comb begin
      addrOk = 1'b0;
      if (paddr[1:0] == 2'b00) begin
         unique case (bank)
            ADDR_CFG_A: addrOk = 1'b1;
            ADDR_PORT_DATA, ADDR_PORT_LATCH, ADDR_OUT_MODE, ADDR_PORT_BIT:
               addrOk = 1'b1;
            ADDR_IN_MODE: addrOk = (paddr == ADDR_IN_MODE);
            default: addrOk = 1'b0;
         endcase
      end
   end

   // Zero-wait slave, data straight from registers
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrOk;
   assign prdata = stateReg.prdata;
   assign pinOut = stateReg.pinOut;
   assign pinOutEnN = ~stateReg.pinDrive;

   // Next value of all state
   always_comb begin
      stateNext = stateReg;
      // Three-stage pin synchroniser, change taken when stages agree
      stateNext.sync1 = pinIn;
      stateNext.sync2 = stateReg.sync1;
      stateNext.sync3 = stateReg.sync2;
      for (int b = 0; b < NUM_PIN; b++) begin
         if (stateReg.sync2[b] == stateReg.sync3[b]) begin
            stateNext.level[b] = stateReg.sync3[b]; //RULE9
         end
      end
      // Drivers follow the allocation one cycle later
      stateNext.pinOut = valueNext; //RULE16
      stateNext.pinDrive = driveNext; //RULE16
      // Read data captured in setup phase
      if (setupRead) begin
         stateNext.prdata = ZERO32;
         unique case (paddr)
            ADDR_CFG_A: stateNext.prdata[7:0] = stateReg.cfgA;
            ADDR_CFG_B: stateNext.prdata[7:0] = stateReg.cfgB;
            ADDR_CFG_C: stateNext.prdata[7:0] = stateReg.cfgC;
            ADDR_CFG_D: stateNext.prdata[7:0] = stateReg.cfgD;
            ADDR_IN_MODE: stateNext.prdata[7:0] = stateReg.inMode;
            default: begin
               if (paddr[1:0] == 2'b00) begin
                  unique case (bank)
                     ADDR_PORT_DATA, ADDR_PORT_BIT:
                        stateNext.prdata[7:0] =
                           pinReadLevel[8*portSel +: 8]; //RULE7
                     ADDR_PORT_LATCH:
                        stateNext.prdata[7:0] =
                           stateReg.latch[portSel]; //RULE8
                     ADDR_OUT_MODE:
                        stateNext.prdata[7:0] = stateReg.outMode[portSel];
                     default: stateNext.prdata = ZERO32;
                  endcase
               end
            end
         endcase
      end
      // Writes take effect in the access phase
      if (accessWrite && addrOk) begin
         // Reserved config bits are masked off
         unique case (paddr)
            ADDR_CFG_A: stateNext.cfgA = pwdata[7:0] & CFG_A_MASK;
            ADDR_CFG_B: stateNext.cfgB = pwdata[7:0] & CFG_B_MASK;
            ADDR_CFG_C: stateNext.cfgC = pwdata[7:0] & CFG_C_MASK;
            ADDR_CFG_D: stateNext.cfgD = pwdata[7:0] & CFG_D_MASK;
            ADDR_IN_MODE: stateNext.inMode = pwdata[7:0];
            default: begin
               unique case (bank)
                  ADDR_PORT_DATA, ADDR_PORT_LATCH:
                     stateNext.latch[portSel] = pwdata[7:0]; //RULE5
                  ADDR_OUT_MODE:
                     stateNext.outMode[portSel] = pwdata[7:0];
                  ADDR_PORT_BIT:
                     // Mask in low byte, values in next byte
                     stateNext.latch[portSel] =
                        (stateReg.latch[portSel] & ~pwdata[7:0]) |
                        (pwdata[15:8] & pwdata[7:0]); //RULE5
                  default: stateNext.latch = stateReg.latch;
               endcase
            end
         endcase
      end
   end

   // Reset to constants, else register the copy
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         stateReg.cfgA <= CFG_RESET;
         stateReg.cfgB <= CFG_RESET;
         stateReg.cfgC <= CFG_RESET;
         stateReg.cfgD <= CFG_RESET;
         stateReg.latch <= {NUM_PORT{LATCH_RESET}};
         stateReg.outMode <= {NUM_PORT{OUT_MODE_RESET}};
         stateReg.inMode <= IN_MODE_RESET;
         stateReg.sync1 <= PIN_RESET;
         stateReg.sync2 <= PIN_RESET;
         stateReg.sync3 <= PIN_RESET;
         stateReg.level <= PIN_RESET;
         stateReg.pinOut <= PIN_RESET;
         stateReg.pinDrive <= ZERO32;
         stateReg.prdata <= ZERO32;
      end else begin
         stateReg <= stateNext;
      end
   end
endmodule
`default_nettype wire

// File: shared/pcx_pkg.sv
// Constants and types shared by the priority pin crossbar
`default_nettype none
package pcx_pkg;
   localparam int NUM_SIG = 30;
   localparam int NUM_PIN = 32;
   localparam int NUM_PORT = 4;
   localparam int SIGW = 5;
   localparam int RANKW = 6;
   localparam int NUM_CEX = 6;

   // Signal indices in priority order
   localparam int SIG_SER0_TX = 0;
   localparam int SIG_SER0_RX = 1;
   localparam int SIG_SCK = 2;
   localparam int SIG_MISO = 3;
   localparam int SIG_MOSI = 4;
   localparam int SIG_NSS = 5;
   localparam int SIG_SDA = 6;
   localparam int SIG_SCL = 7;
   localparam int SIG_SER1_TX = 8;
   localparam int SIG_SER1_RX = 9;
   localparam int SIG_CNT_OUT = 10;
   localparam int SIG_EXT_CLK = 16;
   localparam int SIG_CMP0 = 17;
   localparam int SIG_CMP1 = 18;
   localparam int SIG_T0 = 19;
   localparam int SIG_INT0 = 20;
   localparam int SIG_T1 = 21;
   localparam int SIG_INT1 = 22;
   localparam int SIG_T2 = 23;
   localparam int SIG_T2_EXT = 24;
   localparam int SIG_T4 = 25;
   localparam int SIG_T4_EXT = 26;
   localparam int SIG_CLK_OUT = 27;
   localparam int SIG_CNV0 = 28;
   localparam int SIG_CNV2 = 29;

   // Input-only signals and always open-drain signals
   localparam logic [NUM_SIG-1:0] INPUT_ONLY_MASK = 30'h37F90202;
   localparam logic [NUM_SIG-1:0] OPEN_DRAIN_MASK = 30'h000000C0;

   // Pin positions
   localparam int PORT_ONE_BASE = 8;
   localparam int EMIF_WR_PIN = 7;
   localparam int EMIF_RD_PIN = 6;
   localparam int EMIF_ALE_PIN = 5;

   // Byte addresses of registers
   localparam logic [7:0] ADDR_CFG_A = 8'h00;
   localparam logic [7:0] ADDR_CFG_B = 8'h04;
   localparam logic [7:0] ADDR_CFG_C = 8'h08;
   localparam logic [7:0] ADDR_CFG_D = 8'h0C;
   localparam logic [7:0] ADDR_PORT_DATA = 8'h10;
   localparam logic [7:0] ADDR_PORT_LATCH = 8'h20;
   localparam logic [7:0] ADDR_OUT_MODE = 8'h30;
   localparam logic [7:0] ADDR_IN_MODE = 8'h40;
   localparam logic [7:0] ADDR_PORT_BIT = 8'h50;
   localparam logic [7:0] ADDR_BANK_MASK = 8'hF0;
   localparam logic [7:0] ADDR_PORT_SEL_HI = 8'h0C;
   localparam int ADDR_PORT_SEL_LSB = 2;

   // Field positions, config A
   localparam int A_SMB = 0;
   localparam int A_SPI = 1;
   localparam int A_UART0 = 2;
   localparam int A_CEX_LSB = 3;
   localparam int A_CEX_MSB = 5;
   localparam int A_EXT_CLK = 6;
   localparam int A_CMP0 = 7;
   // Config B
   localparam int B_CMP1 = 0;
   localparam int B_T0 = 1;
   localparam int B_INT0 = 2;
   localparam int B_T1 = 3;
   localparam int B_INT1 = 4;
   localparam int B_T2 = 5;
   localparam int B_T2_EXT = 6;
   localparam int B_CLK_OUT = 7;
   // Config C
   localparam int C_CNV0 = 0;
   localparam int C_UART1 = 2;
   localparam int C_GLOBAL = 4;
   localparam int C_EMIF = 5;
   // Config D
   localparam int D_T4 = 0;
   localparam int D_T4_EXT = 1;
   localparam int D_CNV2 = 2;
   localparam int D_EMIF_MUX = 3;
   localparam logic [7:0] CFG_A_MASK = 8'hFF;
   localparam logic [7:0] CFG_B_MASK = 8'hFF;
   localparam logic [7:0] CFG_C_MASK = 8'h35;
   localparam logic [7:0] CFG_D_MASK = 8'h0F;

   // Reset values
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   localparam logic [7:0] OUT_MODE_RESET = 8'h00;
   localparam logic [7:0] IN_MODE_RESET = 8'hFF;
   localparam logic [31:0] PIN_RESET = 32'hFFFFFFFF;
   localparam logic [31:0] ZERO32 = 32'h00000000;

   typedef struct packed {
      logic [7:0] cfgA;
      logic [7:0] cfgB;
      logic [7:0] cfgC;
      logic [7:0] cfgD;
      logic [NUM_PORT-1:0][7:0] latch;
      logic [NUM_PORT-1:0][7:0] outMode;
      logic [7:0] inMode;
      logic [NUM_PIN-1:0] sync1;
      logic [NUM_PIN-1:0] sync2;
      logic [NUM_PIN-1:0] sync3;
      logic [NUM_PIN-1:0] level;
      logic [NUM_PIN-1:0] pinOut;
      logic [NUM_PIN-1:0] pinDrive;
      logic [31:0] prdata;
   } pcx_state_t;
endpackage
`default_nettype wire

// File: hdl/pcx_allocator.sv
// Sequential pin allocation from enabled signals and skipped pins
`timescale 1ns/100ps
`default_nettype none
module pcx_allocator
   import pcx_pkg::*;
(
   // Requests
   input wire logic [NUM_SIG-1:0] sigEnable,
   input wire logic [NUM_PIN-1:0] pinSkip,
   // Pin side map
   output logic [NUM_PIN-1:0] pinOwned,
   output logic [NUM_PIN-1:0][SIGW-1:0] pinSig,
   // Signal side map
   output logic [NUM_SIG-1:0] sigHasPin,
   output logic [NUM_SIG-1:0][SIGW-1:0] sigPin
);
   logic [NUM_PIN-1:0][RANKW-1:0] pinRank;
   logic [NUM_SIG-1:0][RANKW-1:0] sigRank;
   logic [RANKW-1:0] rank;
   logic [RANKW-1:0] srank;

   always_comb begin
      rank = '0;
      srank = '0;
      pinOwned = '0;
      pinSig = '0;
      sigHasPin = '0;
      sigPin = '0;
      // Free pins counted upward from the lowest pin
      for (int p = 0; p < NUM_PIN; p++) begin
         pinRank[p] = rank;
         if (!pinSkip[p]) begin
            rank = rank + 1'b1;
         end
      end
      // Enabled signals counted in priority order
      for (int s = 0; s < NUM_SIG; s++) begin
         sigRank[s] = srank; //RULE4
         if (sigEnable[s]) begin
            srank = srank + 1'b1;
         end
      end
      // Next free pin goes to next enabled signal
      for (int p = 0; p < NUM_PIN; p++) begin
         for (int s = 0; s < NUM_SIG; s++) begin
            if (!pinSkip[p] && sigEnable[s] && pinRank[p] == sigRank[s]) begin //RULE13
               pinOwned[p] = 1'b1;
               pinSig[p] = SIGW'(s);
               sigHasPin[s] = 1'b1;
               sigPin[s] = SIGW'(p);
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/pcx_crossbar_asserts.sv
// Port-level assertions for the priority pin crossbar
`timescale 1ns/100ps
`default_nettype none
module pcx_crossbar_asserts
   import pcx_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Peripheral side
   input wire logic [NUM_SIG-1:0] periphOut,
   input wire logic [NUM_SIG-1:0] periphDrive,
   input wire logic spiThreeWire,
   input wire logic [NUM_SIG-1:0] periphIn,
   input wire logic [NUM_SIG-1:0] periphHasPin,
   // Port pins
   input wire logic [NUM_PIN-1:0] pinIn,
   input wire logic [NUM_PIN-1:0] pinOut,
   input wire logic [NUM_PIN-1:0] pinOutEnN
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   serial_zero_pair_a: assert property (
      periphHasPin[SIG_SER0_TX] == periphHasPin[SIG_SER0_RX])
      else $error("serial zero pins split");
   spi_lines_together_a: assert property (
      periphHasPin[SIG_SCK] == periphHasPin[SIG_MISO] &&
      periphHasPin[SIG_MISO] == periphHasPin[SIG_MOSI])
      else $error("spi pins split");
   two_wire_pair_a: assert property (
      periphHasPin[SIG_SDA] == periphHasPin[SIG_SCL])
      else $error("two-wire pins split");
   idle_input_high_a: assert property (
      &(periphIn | periphHasPin))
      else $error("pinless peripheral input not high");
   access_ready_a: assert property (
      psel && penable |-> pready)
      else $error("no ready in access phase");
   refused_read_zero_a: assert property (
      pslverr |-> psel && penable && (pwrite || prdata == 32'h00000000))
      else $error("bad error response");
   alloc_after_write_a: assert property (
      $changed(periphHasPin) && $stable(spiThreeWire)
      |-> $past(psel && penable && pwrite))
      else $error("allocation changed without a write");
   reset_drivers_off_a: assert property (
      $fell(reset) |-> (&pinOutEnN) [*2])
      else $error("driver on after reset");
   read_data_holds_a: assert property (
      !$past(psel && !penable) |-> $stable(prdata))
      else $error("read data moved outside setup");

   cover property (periphHasPin[SIG_SER0_TX]);
   cover property (pslverr);
   cover property (!(&pinOutEnN));
endmodule

bind pcx_crossbar pcx_crossbar_asserts i_pcx_crossbar_asserts (
   .core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .periphOut, .periphDrive, .spiThreeWire,
   .periphIn, .periphHasPin, .pinIn, .pinOut, .pinOutEnN
);
`default_nettype wire

// File: verification/pcx_pin_board.sv
// Board model of the port pins: wired-AND with weak pull-ups
`timescale 1ns/100ps
`default_nettype none
module pcx_pin_board
   import pcx_pkg::*;
(
   // Device pins
   input wire logic [NUM_PIN-1:0] pinOut,
   input wire logic [NUM_PIN-1:0] pinOutEnN,
   // Board drivers
   input wire logic [NUM_PIN-1:0] extDrive,
   input wire logic [NUM_PIN-1:0] extVal,
   // Resolved levels
   output logic [NUM_PIN-1:0] pinIn
);
   // Any low driver wins, released pins float up
   assign pinIn = ~(~pinOutEnN & ~pinOut) & ~(extDrive & ~extVal);
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Directed testbench for the priority pin crossbar
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import pcx_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NUM_SIG-1:0] periphOut = '1;
   logic [NUM_SIG-1:0] periphDrive = '1;
   logic spiThreeWire = 1'b0;
   logic [NUM_SIG-1:0] periphIn;
   logic [NUM_SIG-1:0] periphHasPin;
   logic [NUM_PIN-1:0] pinIn;
   logic [NUM_PIN-1:0] pinOut;
   logic [NUM_PIN-1:0] pinOutEnN;
   logic [NUM_PIN-1:0] extDrive = '0;
   logic [NUM_PIN-1:0] extVal = '1;
   logic [31:0] rd;
   logic er;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;

   pcx_crossbar i_pcx_crossbar (.core_clk, .reset, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .periphOut,
      .periphDrive, .spiThreeWire, .periphIn, .periphHasPin, .pinIn,
      .pinOut, .pinOutEnN);
   pcx_pin_board i_pcx_pin_board (.pinOut, .pinOutEnN, .extDrive,
      .extVal, .pinIn);

   always #5 core_clk = ~core_clk;

   task results();
      $display("Checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task w(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task apb(input logic isWr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= isWr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdChk(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h00000000);
      chk("read data", e, rd);
      chk("read error", 32'(ee), 32'(er));
   endtask

   initial begin
      w(2);
      reset <= 1'b0;
      w(1);
      chk("reset enables", PIN_RESET, pinOutEnN);
      rdChk(ADDR_CFG_C, 32'(CFG_RESET), 1'b0);
      rdChk(ADDR_PORT_LATCH, 32'(LATCH_RESET), 1'b0);
      rdChk(ADDR_OUT_MODE, 32'(OUT_MODE_RESET), 1'b0);
      rdChk(ADDR_IN_MODE, 32'(IN_MODE_RESET), 1'b0);
      rdChk(8'h60, 32'h00000000, 1'b1);
      rdChk(8'h02, 32'h00000000, 1'b1);
      wr(8'h60, 32'h000000FF);
      chk("unmapped write", 32'h1, 32'(er));
      // GPIO set up while the drivers are still gated
      wr(ADDR_OUT_MODE, 32'h000000FF);
      wr(ADDR_PORT_DATA, 32'h000000A5);
      w(6);
      chk("gated enables", 32'hFF, 32'(pinOutEnN[7:0]));
      rdChk(ADDR_PORT_DATA, 32'h000000FF, 1'b0);
      rdChk(ADDR_PORT_LATCH, 32'h000000A5, 1'b0);
      wr(ADDR_CFG_C, 32'h00000010);
      w(6);
      chk("gpio enables", 32'h00, 32'(pinOutEnN[7:0]));
      chk("gpio levels", 32'hA5, 32'(pinOut[7:0]));
      rdChk(ADDR_PORT_DATA, 32'h000000A5, 1'b0);
      wr(ADDR_PORT_BIT, 32'h00008081);
      rdChk(ADDR_PORT_LATCH, 32'h000000A4, 1'b0);
      extDrive[15:8] <= 8'hFF;
      extVal[15:8] <= 8'h3C;
      // Read at once still sees the old filtered level
      rdChk(ADDR_PORT_DATA + 8'h04, 32'h000000FF, 1'b0);
      w(6);
      rdChk(ADDR_PORT_DATA + 8'h04, 32'h0000003C, 1'b0);
      wr(ADDR_IN_MODE, 32'h000000F0);
      w(6);
      rdChk(ADDR_PORT_DATA + 8'h04, 32'h00000030, 1'b0);
      // Serial port zero takes the two lowest pins
      wr(ADDR_CFG_A, 32'h00000004);
      w(6);
      chk("serial zero pins", 32'h3, 32'(periphHasPin));
      chk("tx over latch", 32'h1, 32'(pinOut[0]));
      chk("rx driver off", 32'h1, 32'(pinOutEnN[1]));
      periphOut[SIG_SER0_TX] <= 1'b0;
      extDrive[1] <= 1'b1;
      extVal[1] <= 1'b0;
      w(6);
      chk("tx level", 32'h0, 32'(pinOut[0]));
      chk("rx input", 32'h0, 32'(periphIn[SIG_SER0_RX]));
      rdChk(ADDR_PORT_DATA, 32'h000000A4, 1'b0);
      // SPI then serial one, with and without the select line
      extDrive[1] <= 1'b0;
      extDrive[7] <= 1'b1;
      extVal[7] <= 1'b0;
      wr(ADDR_CFG_A, 32'h00000006);
      wr(ADDR_CFG_C, 32'h00000014);
      w(6);
      chk("rx1 after select", 32'h0, 32'(periphIn[SIG_SER1_RX]));
      spiThreeWire <= 1'b1;
      w(6);
      chk("no select pin", 32'h0, 32'(periphHasPin[SIG_NSS]));
      chk("rx1 moved down", 32'h1, 32'(periphIn[SIG_SER1_RX]));
      extDrive[6] <= 1'b1;
      extVal[6] <= 1'b0;
      w(6);
      chk("rx1 at pin six", 32'h0, 32'(periphIn[SIG_SER1_RX]));
      // Reserved strobes and analog pins are skipped
      spiThreeWire <= 1'b0;
      extDrive[7:6] <= 2'b00;
      extVal[15:8] <= 8'hEF;
      wr(ADDR_CFG_A, 32'h00000034);
      wr(ADDR_CFG_C, 32'h00000030);
      wr(ADDR_CFG_D, 32'h00000008);
      w(6);
      chk("counter out three", 32'h0, 32'(periphIn[SIG_CNT_OUT + 3]));
      chk("counter out four", 32'h1, 32'(periphIn[SIG_CNT_OUT + 4]));
      wr(ADDR_CFG_C, 32'h00000000);
      w(6);
      chk("global off", PIN_RESET, pinOutEnN);
      chk("no pins", 32'h0, 32'(periphHasPin));
      // Reset in mid-run restores configuration and latches
      reset <= 1'b1;
      w(2);
      reset <= 1'b0;
      w(1);
      rdChk(ADDR_CFG_A, 32'(CFG_RESET), 1'b0);
      rdChk(ADDR_PORT_LATCH, 32'(LATCH_RESET), 1'b0);
      results();
   end
endmodule
`default_nettype wire
